// ==== rkf_crc.sv ====
// Two-bit check value over the 65 leading bits of a code word
`timescale 1ns/10ps
module rkf_crc
  import rkf_pkg::*;
(
  input wire logic [RKF_DATA_BITS-1:0] bits_i,
  output logic [1:0] crc_o
);

  always_comb begin
    logic [1:0] c;
    logic t;
    c = 2'h0;
    t = 1'b0;
    // Bit 0 enters first, matching the order on air
    for (int n = 0; n < RKF_DATA_BITS; n++) begin
      t = c[0] ^ bits_i[n];
      c = {t, t ^ c[1]};
    end
    crc_o = c;
  end

endmodule : rkf_crc

// ==== rkf_framer.sv ====
// Transmit framer: wake-up, preamble, header, modulated bits, guard, radio enable and indicator
// Summary of operation
// - Transmission repeats code words: preamble, header, data, then guard interval.
// - Guard interval selectable as zero, 6.4, 51.2 or 102.4 ms.
// - Timing element selectable as 100, 200, 400 or 800 us.
// - Header lasts four or ten timing elements.
// - Guard, timing element and header length are per encoder configuration.
// - Four bit formats: pulse width, Manchester, variable width, pulse position.
// - Optional leading and trailing one bit around each code word.
// - Optional wake-up burst of 50, 75 or 100 ms before a transmission.
// - Wake-up setting is shared by both configurations.
// - With the option set, the shared pin drives radio enable high while sending.
// - Radio enable option blocks second configuration selection through the pin.
// - Radio enable drops only after the last word's guard interval.
// - Synthesizer setting picks ASK or FSK startup order of enable and data.
// - Indicator sinks while sending; on 50 or 100 ms, off 500 ms.
// - Low battery: no blinking unless blink option, then exactly one flash.
// - Two check bits over hop part, fixed part and low battery bit.
// - Check register starts at zero and is updated per bit as specified.
// - Queueing off: second press waits for minimum word count; words 67 bits, 69 with framing bits.
// - Queueing on: saturating two-bit counter, bumped by presses within 2 s.
// - Queueing on: a queued press cuts the current word short.
// - Queueing enable is per encoder configuration.
// - Data bits go out least significant bit first.
`timescale 1ns/10ps
module rkf_framer
  import rkf_pkg::*;
#(
  parameter int BASE_CYC = RKF_BASE_CYC,
  parameter int MIN_WORDS = RKF_MIN_WORDS
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic press_i,
  input wire logic select_i,
  input wire logic low_battery_flag_i,
  input wire rkf_cfg_t cfg1_i,
  input wire rkf_cfg_t cfg2_i,
  input wire logic [1:0] wake_select_i,
  input wire logic radio_enable_output_option_i,
  input wire logic synth_interface_select_i,
  input wire logic indicator_on_time_select_i,
  input wire logic indicator_low_battery_blink_i,
  input wire rkf_word_t word_i,
  output logic data_o,
  output logic select_o,
  output logic select_oe_o,
  output logic indicator_sink_o,
  output logic busy_o,
  output logic [1:0] queue_count_o
);

  localparam int BW = $clog2(BASE_CYC);

  typedef enum logic [2:0] {S_IDLE, S_LEAD, S_WAKE, S_PRE, S_HDR, S_BIT, S_GUARD} rkf_state_t;

  rkf_state_t state;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic press_s;
  logic sel_s;
  logic lowbat_s;
  logic press_prev;
  logic press_rise;
  logic [BW-1:0] base_cnt;
  logic tick;
  logic [2:0] te_cnt;
  logic [2:0] te_last;
  logic te_par;
  logic te_tick;
  rkf_cfg_t sel_cfg;
  rkf_cfg_t cur_cfg;
  logic [70:0] frame;
  logic [6:0] frame_len;
  logic [70:0] next_frame;
  logic [6:0] next_len;
  logic [RKF_DATA_BITS-1:0] data65;
  logic [1:0] crc;
  logic [3:0] slot;
  logic [3:0] hdr_last;
  logic [1:0] sub;
  logic [6:0] bidx;
  logic [5:0] pat;
  logic [10:0] long_cnt;
  logic [10:0] guard_tk;
  logic [10:0] wake_tk;
  logic [7:0] w_cnt;
  logic met;
  logic word_end;
  logic new_word;
  logic load;
  logic abort;
  logic pending;
  logic busy;
  logic next_data;
  rkf_state_t after_end;
  logic [14:0] win_cnt;
  logic [1:0] q_cnt;
  logic [1:0] next_q;
  logic [12:0] led_cnt;
  logic [12:0] on_tk;
  logic flashed;

  // Pins from outside pass two flops before use
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {low_battery_flag_i, select_i, press_i};
      pin_sync <= pin_meta;
    end
  end

  assign press_s = pin_sync[0];
  assign sel_s = pin_sync[1];
  assign lowbat_s = pin_sync[2];
  assign press_rise = press_s & ~press_prev;
  assign busy = state != S_IDLE;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      press_prev <= 1'b0;
    end else begin
      press_prev <= press_s;
    end
  end

  // Free-running base tick at the shortest timing element
  assign tick = base_cnt == BW'(BASE_CYC - 1);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      base_cnt <= '0;
    end else begin
      base_cnt <= tick ? '0 : base_cnt + 1'b1;
    end
  end

  // Configuration in force for the next word; the option pin cannot pick the second
  assign sel_cfg = (sel_s && !radio_enable_output_option_i) ? cfg2_i : cfg1_i;

  // Timing element: 1, 2, 4 or 8 base ticks
  assign te_last = 3'((4'h1 << cur_cfg.timing_element_select) - 4'h1);
  assign te_tick = tick && te_cnt == te_last;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      te_cnt <= 3'h0;
      te_par <= 1'b0;
    end else if (load || !busy) begin
      te_cnt <= 3'h0;
      te_par <= 1'b0;
    end else if (tick) begin
      te_cnt <= te_tick ? 3'h0 : te_cnt + 3'h1;
      te_par <= te_tick ? ~te_par : te_par;
    end
  end

  assign hdr_last = cur_cfg.header_long ? 4'(RKF_HDR_LONG_TE - 1) : 4'(RKF_HDR_SHORT_TE - 1);

  always_comb begin
    case (cur_cfg.guard_interval_select)
      2'h0: guard_tk = 11'h0;
      2'h1: guard_tk = 11'(RKF_GUARD1_TK);
      2'h2: guard_tk = 11'(RKF_GUARD2_TK);
      default: guard_tk = 11'(RKF_GUARD3_TK);
    endcase
    case (wake_select_i)
      2'h0: wake_tk = 11'h0;
      2'h1: wake_tk = 11'(RKF_WAKE1_TK);
      2'h2: wake_tk = 11'(RKF_WAKE2_TK);
      default: wake_tk = 11'(RKF_WAKE3_TK);
    endcase
  end

  // Bit pattern: top two bits are slot count minus one, low four the level per slot
  function automatic logic [5:0] bit_pat(input logic [1:0] fmt, input logic b);
    case (fmt)
      RKF_FMT_PWM: bit_pat = b ? 6'h21 : 6'h23;
      RKF_FMT_MAN: bit_pat = b ? 6'h12 : 6'h11;
      RKF_FMT_VPWM: bit_pat = b ? 6'h11 : 6'h23;
      default: bit_pat = b ? 6'h22 : 6'h21;
    endcase
  endfunction : bit_pat

  assign pat = bit_pat(cur_cfg.modulation_format_select, frame[bidx]);

  // Word payload and its check bits
  assign data65 = {lowbat_s, word_i.fixed_part, word_i.hop_part};

  rkf_crc u_crc (
    .bits_i(data65),
    .crc_o(crc)
  );

  // Queue counter value that the next loaded word carries
  always_comb begin
    next_q = q_cnt;
    if (press_rise) begin
      if (win_cnt < 15'(RKF_QWIN_TK)) begin
        next_q = (q_cnt == 2'h3) ? 2'h3 : q_cnt + 2'h1;
      end else begin
        next_q = 2'h0;
      end
    end
  end

  // Frame assembly, bit 0 goes out first
  always_comb begin
    next_frame = '0;
    next_len = 7'h0;
    if (sel_cfg.framing_bits_enable) begin
      next_frame[0] = 1'b1;
      next_len = 7'h1;
    end
    next_frame = next_frame | (71'({crc, data65}) << next_len);
    next_len = next_len + 7'(RKF_WORD_BITS);
    if (sel_cfg.press_queue_enable) begin
      next_frame = next_frame | (71'(next_q) << next_len);
      next_len = next_len + 7'(RKF_QUEUE_BITS);
    end
    if (sel_cfg.framing_bits_enable) begin
      next_frame[next_len] = 1'b1;
      next_len = next_len + 7'h1;
    end
  end

  // Word sequencing decisions
  assign met = (9'(w_cnt) + 9'h1) >= 9'(MIN_WORDS);
  assign word_end = (state == S_BIT && te_tick && sub == pat[5:4] && bidx == frame_len - 7'h1
                     && guard_tk == 11'h0) || (state == S_GUARD && tick && long_cnt == guard_tk - 11'h1);
  assign new_word = word_end && pending && met;
  assign abort = busy && press_rise && cur_cfg.press_queue_enable;
  assign load = (!busy && press_rise) || new_word || abort;
  assign after_end = ((pending && met) || press_s || !met) ? S_PRE : S_IDLE;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cur_cfg <= '0;
      frame <= '0;
      frame_len <= 7'h0;
    end else if (load) begin
      cur_cfg <= sel_cfg;
      frame <= next_frame;
      frame_len <= next_len;
    end
  end

  // Second press held back until the minimum word count is done
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pending <= 1'b0;
    end else if (busy && press_rise && !cur_cfg.press_queue_enable) begin
      pending <= 1'b1;
    end else if (new_word) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      w_cnt <= 8'h0;
    end else if (load) begin
      w_cnt <= 8'h0;
    end else if (word_end && w_cnt != 8'hff) begin
      w_cnt <= w_cnt + 8'h1;
    end
  end

  // Window since the last press start; starts out of window
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      win_cnt <= 15'(RKF_QWIN_TK);
      q_cnt <= 2'h0;
    end else begin
      q_cnt <= next_q;
      if (press_rise) begin
        win_cnt <= 15'h0;
      end else if (tick && win_cnt != 15'(RKF_QWIN_TK)) begin
        win_cnt <= win_cnt + 15'h1;
      end
    end
  end

  // Sequencer
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= S_IDLE;
      slot <= 4'h0;
      sub <= 2'h0;
      bidx <= 7'h0;
      long_cnt <= 11'h0;
    end else if (abort || new_word) begin
      state <= S_PRE;
      slot <= 4'h0;
      sub <= 2'h0;
      bidx <= 7'h0;
      long_cnt <= 11'h0;
    end else begin
      case (state)
        S_IDLE: begin
          slot <= 4'h0;
          sub <= 2'h0;
          bidx <= 7'h0;
          long_cnt <= 11'h0;
          if (press_rise) begin
            // FSK keys the synthesizer one element before any data
            state <= synth_interface_select_i ? S_LEAD : (wake_tk != 11'h0 ? S_WAKE : S_PRE);
          end
        end
        S_LEAD: begin
          if (te_tick) begin
            state <= (wake_tk != 11'h0) ? S_WAKE : S_PRE;
          end
        end
        S_WAKE: begin
          if (tick) begin
            if (long_cnt == wake_tk - 11'h1) begin
              long_cnt <= 11'h0;
              state <= S_PRE;
            end else begin
              long_cnt <= long_cnt + 11'h1;
            end
          end
        end
        S_PRE: begin
          if (te_tick) begin
            if (slot == 4'(RKF_PRE_TE - 1)) begin
              slot <= 4'h0;
              state <= S_HDR;
            end else begin
              slot <= slot + 4'h1;
            end
          end
        end
        S_HDR: begin
          if (te_tick) begin
            if (slot == hdr_last) begin
              slot <= 4'h0;
              state <= S_BIT;
            end else begin
              slot <= slot + 4'h1;
            end
          end
        end
        S_BIT: begin
          if (te_tick) begin
            if (sub == pat[5:4]) begin
              sub <= 2'h0;
              if (bidx == frame_len - 7'h1) begin
                bidx <= 7'h0;
                state <= (guard_tk == 11'h0) ? after_end : S_GUARD;
              end else begin
                bidx <= bidx + 7'h1;
              end
            end else begin
              sub <= sub + 2'h1;
            end
          end
        end
        S_GUARD: begin
          if (tick) begin
            if (long_cnt == guard_tk - 11'h1) begin
              long_cnt <= 11'h0;
              state <= after_end;
            end else begin
              long_cnt <= long_cnt + 11'h1;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Line level; low in idle, lead-in, header and guard
  always_comb begin
    case (state)
      S_WAKE: next_data = ~te_par;
      S_PRE: next_data = ~slot[0];
      S_BIT: next_data = pat[sub];
      default: next_data = 1'b0;
    endcase
  end

  // Data and radio enable share one register stage so they stay aligned
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_o <= 1'b0;
      select_o <= 1'b0;
      select_oe_o <= 1'b0;
      busy_o <= 1'b0;
      queue_count_o <= 2'h0;
    end else begin
      data_o <= next_data;
      select_o <= radio_enable_output_option_i && busy;
      select_oe_o <= radio_enable_output_option_i;
      busy_o <= busy;
      queue_count_o <= q_cnt;
    end
  end

  // Indicator: first flash at start, then off/on cycles
  assign on_tk = indicator_on_time_select_i ? 13'(RKF_LED_ON2_TK) : 13'(RKF_LED_ON1_TK);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      indicator_sink_o <= 1'b0;
      led_cnt <= 13'h0;
      flashed <= 1'b0;
    end else if (!busy) begin
      indicator_sink_o <= 1'b0;
      led_cnt <= 13'h0;
      flashed <= 1'b0;
    end else if (lowbat_s && !indicator_low_battery_blink_i) begin
      indicator_sink_o <= 1'b0;
    end else if (tick) begin
      if (indicator_sink_o) begin
        if (led_cnt == on_tk - 13'h1) begin
          indicator_sink_o <= 1'b0;
          led_cnt <= 13'h0;
          flashed <= 1'b1;
        end else begin
          led_cnt <= led_cnt + 13'h1;
        end
      end else if (!flashed) begin
        indicator_sink_o <= 1'b1;
        led_cnt <= 13'h0;
      end else if (!lowbat_s) begin
        // A low battery leaves only the single flash
        if (led_cnt == 13'(RKF_LED_OFF_TK - 1)) begin
          indicator_sink_o <= 1'b1;
          led_cnt <= 13'h0;
        end else begin
          led_cnt <= led_cnt + 13'h1;
        end
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  guard_line_low_a: assert property ((state == S_GUARD) |=> !data_o)
    else $error("Data high during guard");
  header_line_low_a: assert property ((state == S_HDR) |=> !data_o)
    else $error("Data high during header");
  radio_with_data_a: assert property ((data_o && radio_enable_output_option_i) |-> select_o)
    else $error("Data sent without radio enable");
  config_lock_a: assert property ((load && radio_enable_output_option_i) |=> cur_cfg == $past(cfg1_i))
    else $error("Second configuration used with radio option");
  radio_drop_a: assert property ($fell(select_o) |-> $past(word_end, 2))
    else $error("Radio enable dropped mid transmission");
  crc_zero_a: assert property ((load && data65 == '0) |=> frame[RKF_DATA_BITS+1 +: 2] == 2'h0 || !frame[0])
    else $error("Check bits nonzero for zero payload");
  framing_lead_a: assert property ((load && sel_cfg.framing_bits_enable) |=> frame[0] && frame_len > 7'h43)
    else $error("Leading framing bit missing");
  queue_sat_a: assert property ((q_cnt == 2'h3 && press_rise && win_cnt < 15'(RKF_QWIN_TK)) |=> q_cnt == 2'h3)
    else $error("Queue counter wrapped");
  queue_cut_a: assert property (abort |=> state == S_PRE && slot == 4'h0 && bidx == 7'h0 && next_data)
    else $error("Queued press did not restart word");
  led_dark_a: assert property ((busy && lowbat_s && !indicator_low_battery_blink_i) |=> !indicator_sink_o)
    else $error("Indicator lit on low battery without blink");

endmodule : rkf_framer

// ==== rkf_pkg.sv ====
// Shared constants and types for the code word transmit framer
package rkf_pkg;

  // Clock and the shortest timing element
  localparam int RKF_CLK_MHZ = 250;
  localparam int RKF_BASE_US = 100;
  localparam int RKF_BASE_CYC = RKF_CLK_MHZ * RKF_BASE_US;

  // Guard intervals, in microseconds and in base ticks
  localparam int RKF_GUARD1_US = 6400;
  localparam int RKF_GUARD2_US = 51200;
  localparam int RKF_GUARD3_US = 102400;
  localparam int RKF_GUARD1_TK = RKF_GUARD1_US / RKF_BASE_US;
  localparam int RKF_GUARD2_TK = RKF_GUARD2_US / RKF_BASE_US;
  localparam int RKF_GUARD3_TK = RKF_GUARD3_US / RKF_BASE_US;

  // Wake-up burst lengths
  localparam int RKF_WAKE1_MS = 50;
  localparam int RKF_WAKE2_MS = 75;
  localparam int RKF_WAKE3_MS = 100;
  localparam int RKF_WAKE1_TK = RKF_WAKE1_MS * 1000 / RKF_BASE_US;
  localparam int RKF_WAKE2_TK = RKF_WAKE2_MS * 1000 / RKF_BASE_US;
  localparam int RKF_WAKE3_TK = RKF_WAKE3_MS * 1000 / RKF_BASE_US;

  // Indicator timing and the press queue window
  localparam int RKF_LED_ON1_MS = 50;
  localparam int RKF_LED_ON2_MS = 100;
  localparam int RKF_LED_OFF_MS = 500;
  localparam int RKF_QWIN_MS = 2000;
  localparam int RKF_LED_ON1_TK = RKF_LED_ON1_MS * 1000 / RKF_BASE_US;
  localparam int RKF_LED_ON2_TK = RKF_LED_ON2_MS * 1000 / RKF_BASE_US;
  localparam int RKF_LED_OFF_TK = RKF_LED_OFF_MS * 1000 / RKF_BASE_US;
  localparam int RKF_QWIN_TK = RKF_QWIN_MS * 1000 / RKF_BASE_US;

  // Frame shape
  localparam int RKF_PRE_TE = 16;
  localparam int RKF_HDR_SHORT_TE = 4;
  localparam int RKF_HDR_LONG_TE = 10;
  localparam int RKF_DATA_BITS = 65;
  localparam int RKF_WORD_BITS = 67;
  localparam int RKF_QUEUE_BITS = 2;
  localparam int RKF_MIN_WORDS = 2;

  // Modulation format codes
  localparam logic [1:0] RKF_FMT_PWM = 2'h0;
  localparam logic [1:0] RKF_FMT_MAN = 2'h1;
  localparam logic [1:0] RKF_FMT_VPWM = 2'h2;
  localparam logic [1:0] RKF_FMT_PPM = 2'h3;

  // One encoder configuration
  typedef struct packed {
    logic [1:0] guard_interval_select;
    logic [1:0] timing_element_select;
    logic header_long;
    logic [1:0] modulation_format_select;
    logic framing_bits_enable;
    logic press_queue_enable;
  } rkf_cfg_t;

  // Code word payload from the cipher side
  typedef struct packed {
    logic [31:0] fixed_part;
    logic [31:0] hop_part;
  } rkf_word_t;

endpackage : rkf_pkg

// ==== rkf_rx_model.sv ====
// Receiver model that decodes pulse-width code words from the serial line
`timescale 1ns/10ps
module rkf_rx_model (
  input wire logic clk_i,
  input wire logic data_i,
  input wire logic [3:0] te_i,
  output logic [68:0] bits_o,
  output int len_o,
  output int words_o
);
  int run = 0;
  int cnt = 0;
  logic prev = 1'b0;
  logic [68:0] acc = '0;
  initial begin
    bits_o = '0;
    len_o = 0;
    words_o = 0;
  end
  // A long low marks header or guard; only segments with many pulses count as words
  always @(posedge clk_i) begin
    if (data_i !== prev) begin
      if (prev === 1'b1 && cnt < 69) begin
        acc[cnt] = (run * 2 <= te_i * 3);
        cnt = cnt + 1;
      end
      run = 1;
    end else begin
      run = run + 1;
      if (data_i !== 1'b1 && run == te_i * 3) begin
        if (cnt >= 60) begin
          bits_o = acc;
          len_o = cnt;
          words_o = words_o + 1;
        end
        cnt = 0;
        acc = '0;
      end
    end
    prev = data_i;
  end
endmodule : rkf_rx_model

// ==== testbench.sv ====
// Self-checking bench for the code word transmit framer
`timescale 1ns/10ps
module testbench;
  import rkf_pkg::*;
  localparam int BC = 4;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic press_i = 1'b0;
  logic select_i = 1'b0;
  logic low_battery_flag_i = 1'b0;
  rkf_cfg_t cfg1_i = '0;
  rkf_cfg_t cfg2_i = '0;
  logic [1:0] wake_select_i = 2'h0;
  logic radio_enable_output_option_i = 1'b0;
  logic synth_interface_select_i = 1'b0;
  logic indicator_on_time_select_i = 1'b0;
  logic indicator_low_battery_blink_i = 1'b0;
  rkf_word_t word_i = {32'h0f1e2d3c, 32'ha5c39617};
  logic data_o, select_o, select_oe_o, indicator_sink_o, busy_o;
  logic [1:0] queue_count_o;
  logic [3:0] te = 4'h4;
  logic [68:0] rx_bits;
  logic seen = 1'b0;
  int rx_len, rx_words, w0;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0, gap = 0, led_on = 0, sel_on = 0, lead = 0, run_up = 0;

  rkf_framer #(.BASE_CYC(BC), .MIN_WORDS(2)) uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .press_i(press_i), .select_i(select_i),
    .low_battery_flag_i(low_battery_flag_i), .cfg1_i(cfg1_i), .cfg2_i(cfg2_i),
    .wake_select_i(wake_select_i), .radio_enable_output_option_i(radio_enable_output_option_i),
    .synth_interface_select_i(synth_interface_select_i),
    .indicator_on_time_select_i(indicator_on_time_select_i),
    .indicator_low_battery_blink_i(indicator_low_battery_blink_i), .word_i(word_i),
    .data_o(data_o), .select_o(select_o), .select_oe_o(select_oe_o),
    .indicator_sink_o(indicator_sink_o), .busy_o(busy_o), .queue_count_o(queue_count_o)
  );
  rkf_rx_model rx (
    .clk_i(clk_i), .data_i(data_o), .te_i(te), .bits_o(rx_bits), .len_o(rx_len), .words_o(rx_words)
  );

  always #2 clk_i = ~clk_i;

  // Trailing low time, indicator, radio enable and startup lead are tallied per transmission
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (data_o === 1'b1) gap <= 0;
    else if (select_o === 1'b1 || busy_o === 1'b1) gap <= gap + 1;
    if (indicator_sink_o === 1'b1) led_on <= led_on + 1;
    if (select_o === 1'b1) sel_on <= sel_on + 1;
    if (data_o === 1'b1) seen <= 1'b1;
    else if (select_o === 1'b1 && !seen) lead <= lead + 1;
    // Run-up lasts until the receiver counts its first word
    if (busy_o === 1'b1 && rx_words == w0) run_up <= run_up + 1;
    if (cyc == 40000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic check(input logic [68:0] got, input logic [68:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Counters are cleared on the falling edge so they never race the monitor
  task automatic press(input int hold);
    @(negedge clk_i);
    gap = 0;
    led_on = 0;
    sel_on = 0;
    lead = 0;
    run_up = 0;
    seen = 1'b0;
    w0 = rx_words;
    @(posedge clk_i);
    press_i <= 1'b1;
    repeat (hold) @(posedge clk_i);
    press_i <= 1'b0;
  endtask : press

  task automatic wait_idle();
    int k;
    k = 0;
    while (busy_o !== 1'b0 && k < 30000) begin
      @(posedge clk_i);
      k++;
    end
    repeat (8) @(posedge clk_i);
  endtask : wait_idle

  function automatic logic [68:0] frame(input rkf_word_t w, input logic lb, input logic st,
                                        input logic [1:0] q, input logic qe);
    logic [64:0] d;
    logic [1:0] c;
    logic t;
    d = {lb, w.fixed_part, w.hop_part};
    c = 2'h0;
    for (int n = 0; n < 65; n++) begin
      t = c[0] ^ d[n];
      c = {t, t ^ c[1]};
    end
    return qe ? {q, c, d} : (st ? {1'b1, c, d, 1'b1} : {2'h0, c, d});
  endfunction : frame

  task automatic check_tx(input int len, input logic [68:0] exp, input int g);
    check(69'(rx_len), 69'(len));
    check(rx_bits, exp);
    check(gap >= g && gap <= g + 3 * te + 4, 1'b1);
  endtask : check_tx

  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    cfg1_i <= {2'h1, 2'h0, 1'b0, RKF_FMT_PWM, 1'b0, 1'b0};
    cfg2_i <= {2'h2, 2'h1, 1'b1, RKF_FMT_PWM, 1'b1, 1'b0};
    press(20);
    wait_idle();
    check(69'(rx_words - w0), 69'd2);
    check_tx(67, frame(word_i, 1'b0, 1'b0, 2'h0, 1'b0), 64 * BC);
    check(led_on > 0, 1'b1);
    check(69'(sel_on), 69'd0);
    select_i <= 1'b1;
    te <= 4'h8;
    press(20);
    wait_idle();
    check_tx(69, frame(word_i, 1'b0, 1'b1, 2'h0, 1'b0), 512 * BC);
    te <= 4'h4;
    low_battery_flag_i <= 1'b1;
    radio_enable_output_option_i <= 1'b1;
    synth_interface_select_i <= 1'b1;
    press(20);
    wait_idle();
    check_tx(67, frame(word_i, 1'b1, 1'b0, 2'h0, 1'b0), 64 * BC);
    check(select_oe_o, 1'b1);
    check(sel_on > 0, 1'b1);
    check(lead >= 1 && lead <= BC, 1'b1);
    check(69'(led_on), 69'd0);
    // Every press after the first fell inside the queue window, so the counter sits at 2 and the next press saturates it at 3
    radio_enable_output_option_i <= 1'b0;
    synth_interface_select_i <= 1'b0;
    low_battery_flag_i <= 1'b0;
    select_i <= 1'b0;
    cfg1_i <= {2'h1, 2'h0, 1'b0, RKF_FMT_PWM, 1'b0, 1'b1};
    press(20);
    repeat (300) @(posedge clk_i);
    press(20);
    repeat (10) @(posedge clk_i);
    check(queue_count_o, 2'h3);
    wait_idle();
    check_tx(69, frame(word_i, 1'b0, 1'b0, 2'h3, 1'b1), 64 * BC);
    // Wake burst ahead of the first preamble; low battery with blink leaves one long flash
    wake_select_i <= 2'h1;
    low_battery_flag_i <= 1'b1;
    indicator_low_battery_blink_i <= 1'b1;
    indicator_on_time_select_i <= 1'b1;
    press(20);
    wait_idle();
    check(run_up >= (RKF_WAKE1_TK + RKF_PRE_TE) * BC && run_up <= (RKF_WAKE1_TK + RKF_PRE_TE + 6) * BC, 1'b1);
    check(69'(led_on), 69'(RKF_LED_ON2_TK * BC));
    check_tx(69, frame(word_i, 1'b1, 1'b0, 2'h3, 1'b1), 64 * BC);
    complete_run();
  end
endmodule : testbench
